// file: logic/fabric_regs.svh
`ifndef FABRIC_REGS_SVH
`define FABRIC_REGS_SVH
`define FAB_N_MC 16
`define FAB_N_GRA 36
`define FAB_N_PT 5
`define FAB_N_GOE 6
`define FAB_CHAIN 8
`define FAB_MAX_SETS 3
`define FAB_N_LIT 52
`define FAB_N_PTMEM 96
`define FAB_SHX_BASE 80
`define FAB_N_SYNC 20
`define PT_CE 2
`define PT_PRE 3
`define PT_CLR 4
`define DED_OE0 2
`define LIT_CL_MASK 52'h0_000F_FFFF_FFFF
`define PT_RST 52'hF_FFFF_FFFF_FFFF
`define GOE_PIN_CODES 6'h04
`define OE_LOW 3'h0
`define OE_HIGH 3'h1
`define OE_GBASE 3'h2
`define CTRL_RUN 0
`define A_CTRL 12'h000
`define A_STATUS 12'h004
`define A_RTE_LO 12'h008
`define A_RTE_HI 12'h00C
`define A_GOE 12'h010
`define A_GOE_END 12'h028
`define A_MC 12'h040
`define A_MC_END 12'h080
`define A_PT 12'h400
`define A_PT_END 12'hA00
`endif

// file: logic/fabric_pkg.sv
`include "fabric_regs.svh"
package fabric_pkg;
    // Per-macrocell configuration word, low field in bit 0.
    typedef struct packed {
        logic lend;
        logic reg_mode;
        logic clk_sel;
        logic clk_inv;
        logic clr_en;
        logic pre_en;
        logic ce_en;
        logic [2:0] oe_sel;
    } mc_cfg_t;
    // Controls that reach one macrocell flip-flop.
    typedef struct packed {
        logic tick;
        logic ce;
        logic clr;
        logic pre;
        logic d;
    } mc_ctl_t;
endpackage : fabric_pkg

// file: logic/sync2.sv
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    // Two stages; only the second stage is ever read by other logic.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule : sync2

// file: logic/mc_ff.sv
`include "fabric_regs.svh"
module mc_ff (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hold_i,
    input fabric_pkg::mc_ctl_t ctl_i,
    output logic q_o
);
    // Clear beats preset, and both act without waiting for a clock tick.
    always_ff @(posedge clk_i) begin
        if (rst_i || hold_i) begin
            q_o <= 1'b0;
        end else if (ctl_i.clr) begin
            q_o <= 1'b0;
        end else if (ctl_i.pre) begin
            q_o <= 1'b1;
        end else if (ctl_i.tick && ctl_i.ce) begin
            q_o <= ctl_i.d;
        end
    end

    a_clear_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        ctl_i.clr |=> !q_o) else $error("Clear did not force the flip-flop low.");
    a_tick_loads: assert property (@(posedge clk_i) disable iff (rst_i)
        (!hold_i && !ctl_i.clr && !ctl_i.pre && ctl_i.tick && ctl_i.ce)
        |=> q_o == $past(ctl_i.d)) else $error("Enabled clock tick did not load data.");
    a_idle_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        (!hold_i && !ctl_i.clr && !ctl_i.pre && !(ctl_i.tick && ctl_i.ce))
        |=> $stable(q_o)) else $error("Flip-flop changed without tick or enable.");
endmodule : mc_ff

// file: logic/product_term_io_fabric.sv
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`include "fabric_regs.svh"
module product_term_io_fabric (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [1:0] gclk_i,
    input wire logic [1:0] goe_pin_i,
    input wire logic [15:0] io_in_i,
    output logic [15:0] io_out_o,
    output logic [15:0] io_oe_o
);
    logic run_reg;
    logic [`FAB_N_GRA-1:0] route_en_reg;
    logic [5:0] goe_sel_reg [`FAB_N_GOE];
    fabric_pkg::mc_cfg_t mc_cfg_reg [`FAB_N_MC];
    logic [`FAB_N_LIT-1:0] pt_t_reg [`FAB_N_PTMEM];
    logic [`FAB_N_LIT-1:0] pt_c_reg [`FAB_N_PTMEM];
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [15:0] io_out_reg;
    logic [15:0] io_oe_reg;
    logic [15:0] fb_reg;
    logic [3:0] ded_d_reg;
    logic [`FAB_N_SYNC-1:0] sync_q;
    logic [3:0] ded_s;
    logic [15:0] pin_s;
    logic [3:0] rise;
    logic [3:0] fall;
    logic req;
    logic cfg_wr;
    logic pt_hit;
    logic goe_hit;
    logic mc_hit;
    logic [11:0] pt_off;
    logic [11:0] goe_off;
    logic [11:0] mc_off;
    logic [6:0] pt_idx;
    logic [2:0] goe_idx;
    logic [3:0] mc_idx;
    logic [31:0] rdata;
    logic [31:0] wdata;
    logic [`FAB_N_GRA-1:0] gra;
    logic [`FAB_N_GRA-1:0] cl_in;
    logic [`FAB_N_LIT-1:0] lit;
    logic [15:0] shx;
    logic [4:0] pt [`FAB_N_MC];
    logic [15:0] own_or;
    logic [15:0] lend_eff;
    logic [15:0] sum;
    logic [15:0] q_vec;
    logic [15:0] mc_out;
    logic [5:0] goe;
    logic [15:0] oe_calc;
    logic [15:0] low_v;
    logic [15:0] high_v;

    // A product term is the AND of the chosen true and complemented literals.
    function automatic logic pterm(input logic [`FAB_N_LIT-1:0] l,
                                   input logic [`FAB_N_LIT-1:0] t,
                                   input logic [`FAB_N_LIT-1:0] c);
        pterm = (&(l | ~t)) & (&(~l | ~c));
    endfunction : pterm

    // Counts contiguous lenders just below macrocell m inside its chain.
    function automatic logic [1:0] borrow_sets(input logic [15:0] lend, input int m);
        logic stop;
        stop = 1'b0;
        borrow_sets = 2'h0;
        for (int k = 1; k <= `FAB_MAX_SETS; k++) begin
            if (!stop && (m % `FAB_CHAIN) >= k && lend[m - k]) begin
                borrow_sets = borrow_sets + 2'h1;
            end else begin
                stop = 1'b1;
            end
        end
    endfunction : borrow_sets

    // Board inputs and clock pins come from outside and are synchronised first.
    sync2 #(.W(`FAB_N_SYNC)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({io_in_i, goe_pin_i, gclk_i}),
        .q_o(sync_q)
    );
    assign pin_s = sync_q[`FAB_N_SYNC-1:4];
    assign ded_s = sync_q[3:0];

    // Edges of the synchronised clock pins become one-cycle tick enables.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ded_d_reg <= 4'h0;
        end else begin
            ded_d_reg <= ded_s;
        end
    end
    assign rise = ded_s & ~ded_d_reg;
    assign fall = ~ded_s & ded_d_reg;

    // Bus decode; answers come one cycle after the request is taken.
    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign cfg_wr = req && wb_we_i && !run_reg;
    assign pt_off = wb_adr_i - `A_PT;
    assign goe_off = wb_adr_i - `A_GOE;
    assign mc_off = wb_adr_i - `A_MC;
    assign pt_hit = wb_adr_i >= `A_PT && wb_adr_i < `A_PT_END;
    assign goe_hit = wb_adr_i >= `A_GOE && wb_adr_i < `A_GOE_END;
    assign mc_hit = wb_adr_i >= `A_MC && wb_adr_i < `A_MC_END;
    assign pt_idx = pt_off[10:4];
    assign goe_idx = goe_off[4:2];
    assign mc_idx = mc_off[5:2];

    // Read mux; unmapped addresses read zero.
    always_comb begin
        rdata = 32'h0000_0000;
        if (pt_hit) begin
            unique case (pt_off[3:2])
                2'h0: rdata = pt_t_reg[pt_idx][31:0];
                2'h1: rdata = 32'(pt_t_reg[pt_idx][`FAB_N_LIT-1:32]);
                2'h2: rdata = pt_c_reg[pt_idx][31:0];
                2'h3: rdata = 32'(pt_c_reg[pt_idx][`FAB_N_LIT-1:32]);
            endcase
        end else if (goe_hit) begin
            rdata = 32'(goe_sel_reg[goe_idx]);
        end else if (mc_hit) begin
            rdata = 32'(mc_cfg_reg[mc_idx]);
        end else begin
            unique case (wb_adr_i)
                `A_CTRL: rdata = 32'(run_reg);
                `A_STATUS: rdata = {pin_s, q_vec};
                `A_RTE_LO: rdata = route_en_reg[31:0];
                `A_RTE_HI: rdata = 32'(route_en_reg[`FAB_N_GRA-1:32]);
                default: rdata = 32'h0000_0000;
            endcase
        end
    end

    // Byte lanes not selected keep their stored value.
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wdata[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] : rdata[8*b +: 8];
        end
    end

    // Bus answer: a single-cycle ack with data captured at the take.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req;
            if (req && !wb_we_i) begin
                dat_reg <= rdata;
            end
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // The run bit stays writable so software can halt the fabric to reload it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_reg <= 1'b0;
        end else if (req && wb_we_i && wb_adr_i == `A_CTRL) begin
            run_reg <= wdata[`CTRL_RUN];
        end
    end

    // Routing enables and global enable sources.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_en_reg <= '0;
            for (int k = 0; k < `FAB_N_GOE; k++) begin
                goe_sel_reg[k] <= 6'h00;
            end
        end else if (cfg_wr) begin
            if (wb_adr_i == `A_RTE_LO) begin
                route_en_reg[31:0] <= wdata;
            end
            if (wb_adr_i == `A_RTE_HI) begin
                route_en_reg[`FAB_N_GRA-1:32] <= wdata[`FAB_N_GRA-33:0];
            end
            if (goe_hit) begin
                goe_sel_reg[goe_idx] <= wdata[5:0];
            end
        end
    end

    // Macrocell configuration and product-term store; reset erases every term.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int m = 0; m < `FAB_N_MC; m++) begin
                mc_cfg_reg[m] <= '0;
            end
            for (int i = 0; i < `FAB_N_PTMEM; i++) begin
                pt_t_reg[i] <= `PT_RST;
                pt_c_reg[i] <= `PT_RST;
            end
        end else if (cfg_wr) begin
            if (mc_hit) begin
                mc_cfg_reg[mc_idx] <= fabric_pkg::mc_cfg_t'(wdata[$bits(fabric_pkg::mc_cfg_t)-1:0]);
            end
            if (pt_hit) begin
                unique case (pt_off[3:2])
                    2'h0: pt_t_reg[pt_idx][31:0] <= wdata;
                    2'h1: pt_t_reg[pt_idx][`FAB_N_LIT-1:32] <= wdata[`FAB_N_LIT-33:0];
                    2'h2: pt_c_reg[pt_idx][31:0] <= wdata;
                    2'h3: pt_c_reg[pt_idx][`FAB_N_LIT-1:32] <= wdata[`FAB_N_LIT-33:0];
                endcase
            end
        end
    end

    // Macrocell outputs re-enter routing through a register, which breaks the
    // combinational loop a feedback path would otherwise form.
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_reg) begin
            fb_reg <= 16'h0000;
        end else begin
            fb_reg <= mc_out;
        end
    end

    // Global routing and the per-cluster AND gating.
    assign gra = {fb_reg, pin_s, ded_s};
    assign cl_in = gra & route_en_reg;

    // Shared expanders: inverted terms computed once and fanned out to all.
    always_comb begin
        for (int k = 0; k < `FAB_N_MC; k++) begin
            shx[k] = ~pterm(`FAB_N_LIT'(cl_in),
                            pt_t_reg[`FAB_SHX_BASE + k] & `LIT_CL_MASK,
                            pt_c_reg[`FAB_SHX_BASE + k] & `LIT_CL_MASK);
        end
    end
    assign lit = {shx, cl_in};

    // Five dedicated terms per macrocell; control terms leave the OR when used.
    always_comb begin
        for (int m = 0; m < `FAB_N_MC; m++) begin
            for (int j = 0; j < `FAB_N_PT; j++) begin
                pt[m][j] = pterm(lit, pt_t_reg[m * `FAB_N_PT + j],
                                 pt_c_reg[m * `FAB_N_PT + j]);
            end
            own_or[m] = |(pt[m] & ~{mc_cfg_reg[m].clr_en, mc_cfg_reg[m].pre_en,
                                    mc_cfg_reg[m].ce_en, 2'b00});
            lend_eff[m] = mc_cfg_reg[m].lend && (m % `FAB_CHAIN) != `FAB_CHAIN - 1;
        end
    end

    // Parallel expanders: each macrocell ORs in up to three lower lenders.
    always_comb begin
        for (int m = 0; m < `FAB_N_MC; m++) begin
            sum[m] = lend_eff[m] ? 1'b0 : own_or[m];
            for (int k = 1; k <= `FAB_MAX_SETS; k++) begin
                if (k <= int'(borrow_sets(lend_eff, m))) begin
                    sum[m] = sum[m] | own_or[m - k];
                end
            end
        end
    end

    // Macrocell flip-flops with their clocks, enables, clears and presets.
    for (genvar g = 0; g < `FAB_N_MC; g++) begin : g_mc
        fabric_pkg::mc_ctl_t ctl;
        always_comb begin
            ctl.tick = mc_cfg_reg[g].clk_inv ? fall[mc_cfg_reg[g].clk_sel]
                                             : rise[mc_cfg_reg[g].clk_sel];
            ctl.ce = !mc_cfg_reg[g].ce_en || pt[g][`PT_CE];
            ctl.pre = mc_cfg_reg[g].pre_en && pt[g][`PT_PRE];
            ctl.clr = mc_cfg_reg[g].clr_en && pt[g][`PT_CLR];
            ctl.d = sum[g];
        end
        mc_ff u_ff (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .hold_i(!run_reg),
            .ctl_i(ctl),
            .q_o(q_vec[g])
        );
        assign mc_out[g] = mc_cfg_reg[g].reg_mode ? q_vec[g] : sum[g];
    end

    // Global enables: enable pins true or inverted, or any routing signal.
    always_comb begin
        for (int k = 0; k < `FAB_N_GOE; k++) begin
            if (goe_sel_reg[k] < `GOE_PIN_CODES) begin
                goe[k] = ded_s[`DED_OE0 + int'(goe_sel_reg[k][1])] ^ goe_sel_reg[k][0];
            end else if (goe_sel_reg[k] - `GOE_PIN_CODES < 6'(`FAB_N_GRA)) begin
                goe[k] = gra[goe_sel_reg[k] - `GOE_PIN_CODES];
            end else begin
                goe[k] = 1'b0;
            end
        end
    end

    // Per-pin enable choice; the pin input path stays live in every case.
    always_comb begin
        for (int m = 0; m < `FAB_N_MC; m++) begin
            low_v[m] = mc_cfg_reg[m].oe_sel == `OE_LOW;
            high_v[m] = mc_cfg_reg[m].oe_sel == `OE_HIGH;
            unique case (mc_cfg_reg[m].oe_sel)
                `OE_LOW: oe_calc[m] = 1'b0;
                `OE_HIGH: oe_calc[m] = 1'b1;
                default: oe_calc[m] = goe[3'(mc_cfg_reg[m].oe_sel - `OE_GBASE)];
            endcase
        end
    end

    // Pin drivers are registered; a halted fabric releases every pin.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_out_reg <= 16'h0000;
            io_oe_reg <= 16'h0000;
        end else begin
            io_out_reg <= mc_out;
            io_oe_reg <= run_reg ? oe_calc : 16'h0000;
        end
    end
    assign io_out_o = io_out_reg;
    assign io_oe_o = io_oe_reg;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !ack_reg;
    endsequence

    a_bus_ack: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Bus ack missing or longer than one cycle.");
    a_cfg_frozen: assert property (run_reg && $past(run_reg) |-> $stable(route_en_reg))
        else $error("Routing changed while running.");
    a_halt_hiz: assert property (!run_reg |=> io_oe_o == 16'h0000)
        else $error("Pin driven while halted.");
    a_oe_low: assert property (##1 (io_oe_o & $past(low_v)) == 16'h0000)
        else $error("Pin tied low is driving.");
    a_oe_high: assert property (run_reg |=> (io_oe_o & $past(high_v)) == $past(high_v))
        else $error("Pin tied high is not driving.");
    a_goe_path: assert property ((run_reg && mc_cfg_reg[0].oe_sel == `OE_GBASE)
        |=> io_oe_o[0] == $past(goe[0])) else $error("Pin 0 ignores global enable 0.");
    a_chain_ends: assert property (borrow_sets(lend_eff, 0) == 2'h0
        && borrow_sets(lend_eff, `FAB_CHAIN) == 2'h0 && !lend_eff[`FAB_CHAIN - 1])
        else $error("Chain end lends or borrows.");
    a_borrow_one: assert property ((lend_eff[6] && !lend_eff[7] && own_or[6]) |-> sum[7])
        else $error("Neighbour terms not borrowed.");
    a_route_gate: assert property ((cl_in & ~route_en_reg) == '0)
        else $error("Ungated signal entered the cluster.");
    a_pin_sync: assert property (##2 (pin_s == $past(io_in_i, 2) || $past(rst_i)
        || $past(rst_i, 2))) else $error("Pin feedback path broken.");
endmodule : product_term_io_fabric

// file: bench/board_pins.sv
module board_pins (
    input wire logic [15:0] io_out_i,
    input wire logic [15:0] io_oe_i,
    input wire logic [15:0] drv_i,
    output logic [15:0] io_in_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven pin shows the fabric's level; otherwise the board's own driver sets it.
    // The board drives every pin weakly, so a released pin never floats to an unknown.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            io_in_o[i] = io_oe_i[i] ? io_out_i[i] : drv_i[i];
        end
    end
endmodule : board_pins

// file: bench/product_term_io_fabric_bench.sv
`include "fabric_regs.svh"
module product_term_io_fabric_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // Row bits from the top: route, enable code[3], enable select[3], enable pins[2],
    // pin level, expected enable, expected data.
    localparam logic [11:0] ROWS [10] = '{12'h827, 12'h822, 12'h026, 12'h804, 12'h84F,
        12'h844, 12'h947, 12'hA57, 12'hB54, 12'hE4F};
    localparam logic [51:0] T_PIN = 52'h0_0000_0008_0000;
    localparam logic [51:0] T_SHX = 52'h0_0010_0000_0000;
    localparam logic [31:0] ROUTE = 32'h0008_0000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [1:0] gclk_drv = 2'h0;
    logic [1:0] goe_drv = 2'h0;
    logic [15:0] pin_drv = 16'h0000;
    logic [15:0] io_in;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [15:0] io_out_o;
    logic [15:0] io_oe_o;
    int failures = 0;
    int samples_checked = 0;

    always #12.5 clk_i = ~clk_i;

    product_term_io_fabric DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .gclk_i(gclk_drv), .goe_pin_i(goe_drv), .io_in_i(io_in),
        .io_out_o(io_out_o), .io_oe_o(io_oe_o));
    board_pins board (.io_out_i(io_out_o), .io_oe_i(io_oe_o), .drv_i(pin_drv), .io_in_o(io_in));

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: bus answer never came", $time);
            results();
        end
    endtask : wb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    // A product term spans four words: true low, true high, complement low, complement high.
    task automatic pt(input int idx, input logic [51:0] t, input logic [51:0] c);
        logic [11:0] base;
        base = `A_PT + 12'(16 * idx);
        wr(base, t[31:0]);
        wr(base + 12'h004, {12'h000, t[51:32]});
        wr(base + 12'h008, c[31:0]);
        wr(base + 12'h00C, {12'h000, c[51:32]});
    endtask : pt

    task automatic run(input logic on);
        wr(`A_CTRL, {31'h0, on});
    endtask : run

    // Pin to output takes three edges; one spare edge covers the enable path too.
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : settle

    // Reset erases every term, so each scenario starts clean with pin 15 routed in.
    task automatic prep();
        @(posedge clk_i);
        rst_i <= 1'b1;
        settle(5);
        rst_i <= 1'b0;
        wr(`A_RTE_LO, ROUTE);
        pt(0, T_PIN, 52'h0);
    endtask : prep

    initial begin
        logic [11:0] r;
        settle(5);
        rst_i <= 1'b0;
        settle(1);
        check({wb_ack_o, io_oe_o, io_out_o}, 32'h0, "outputs after reset");
        wb(1'b0, `A_CTRL, 32'h0, rdat);
        check(rdat, 32'h0, "control after reset");
        wb(1'b0, `A_MC, 32'h0, rdat);
        check(rdat, 32'h0, "macrocell config after reset");
        pt(0, T_PIN, 52'h0);
        // Table rows: routing gate, both enable pins true and inverted, one routing signal via global enable 0, and both tied levels.
        for (int i = 0; i < 10; i++) begin
            r = ROWS[i];
            run(1'b0);
            wr(`A_RTE_LO, r[11] ? ROUTE : 32'h0);
            wr(`A_GOE, {29'h0, r[10:8]});
            wr(`A_MC, {29'h0, r[7:5]});
            pin_drv[15] <= r[2];
            goe_drv <= r[4:3];
            run(1'b1);
            settle(4);
            check({31'h0, io_oe_o[0]}, {31'h0, r[1]}, "pin enable");
            if (r[1]) check({31'h0, io_out_o[0]}, {31'h0, r[0]}, "pin data");
        end
        // Configuration writes while running are ignored; unmapped places read zero.
        wr(`A_RTE_LO, 32'h0);
        wb(1'b0, `A_RTE_LO, 32'h0, rdat);
        check(rdat, ROUTE, "routing changed while running");
        wb(1'b0, 12'h030, 32'h0, rdat);
        check(rdat, 32'h0, "unmapped read");
        wb(1'b0, `A_STATUS, 32'h0, rdat);
        check({31'h0, rdat[31]}, 32'h1, "pin feedback");
        check({31'h0, io_oe_o[15]}, 32'h0, "input pin driven");
        // Each of the five own terms alone reaches the OR logic.
        prep();
        pt(0, `PT_RST, `PT_RST);
        wr(`A_MC, 32'h1);
        pin_drv[15] <= 1'b1;
        for (int j = 0; j < 5; j++) begin
            pt(j, T_PIN, 52'h0);
            run(1'b1);
            settle(4);
            check({31'h0, io_out_o[0]}, 32'h1, "own term");
            run(1'b0);
            pt(j, `PT_RST, `PT_RST);
        end
        run(1'b1);
        settle(4);
        check({31'h0, io_out_o[0]}, 32'h0, "erased terms");
        // One shared expander feeds two macrocells inverted.
        prep();
        pt(80, T_PIN, 52'h0);
        pt(0, T_SHX, 52'h0);
        pt(5, T_SHX, 52'h0);
        wr(`A_MC, 32'h1);
        wr(`A_MC + 12'h004, 32'h1);
        run(1'b1);
        for (int v = 0; v < 2; v++) begin
            pin_drv[15] <= v[0];
            settle(4);
            check({30'h0, io_out_o[1:0]}, {30'h0, {2{~v[0]}}}, "shared term");
        end
        // Lending inside a chain, none across it, and no fourth set.
        prep();
        pt(35, T_PIN, 52'h0);
        wr(`A_MC, 32'h200);
        wr(`A_MC + 12'h01C, 32'h200);
        wr(`A_MC + 12'h004, 32'h1);
        wr(`A_MC + 12'h020, 32'h1);
        pin_drv[15] <= 1'b1;
        run(1'b1);
        settle(4);
        check({31'h0, io_out_o[1]}, 32'h1, "borrowed term");
        check({31'h0, io_out_o[8]}, 32'h0, "chain crossing");
        run(1'b0);
        for (int m = 1; m < 4; m++) wr(`A_MC + 12'(4 * m), 32'h200);
        wr(`A_MC + 12'h010, 32'h1);
        run(1'b1);
        settle(4);
        check({31'h0, io_out_o[4]}, 32'h0, "fourth lender");
        // Registered output loads only on the chosen clock edge.
        prep();
        wr(`A_MC, 32'h101);
        run(1'b1);
        settle(8);
        check({31'h0, io_out_o[0]}, 32'h0, "load without tick");
        gclk_drv[0] <= 1'b1;
        settle(8);
        check({31'h0, io_out_o[0]}, 32'h1, "load on rise");
        pin_drv[15] <= 1'b0;
        gclk_drv[0] <= 1'b0;
        settle(8);
        check({31'h0, io_out_o[0]}, 32'h1, "no load on fall");
        run(1'b0);
        wr(`A_MC, 32'h141);
        pin_drv[15] <= 1'b1;
        run(1'b1);
        gclk_drv[0] <= 1'b1;
        settle(8);
        check({31'h0, io_out_o[0]}, 32'h0, "inverted clock rise");
        gclk_drv[0] <= 1'b0;
        settle(8);
        check({31'h0, io_out_o[0]}, 32'h1, "inverted clock fall");
        // Preset and clear act without a tick, clear wins, and a low enable term blocks a tick.
        run(1'b0);
        pt(3, T_PIN, 52'h0);
        wr(`A_MC, 32'h111);
        run(1'b1);
        settle(4);
        check({31'h0, io_out_o[0]}, 32'h1, "preset without tick");
        run(1'b0);
        pt(4, T_PIN, 52'h0);
        wr(`A_MC, 32'h131);
        run(1'b1);
        settle(4);
        check({31'h0, io_out_o[0]}, 32'h0, "clear over preset");
        run(1'b0);
        wr(`A_MC, 32'h109);
        run(1'b1);
        gclk_drv[0] <= 1'b1;
        settle(8);
        check({31'h0, io_out_o[0]}, 32'h0, "enable term low");
        results();
    end
endmodule : product_term_io_fabric_bench
